//--- fts_sequencer.sv
`timescale 1ns/1ps
// Operation
// - Low word read in word mode returns program bits 15..0.
// - Low word byte read returns upper or lower low-word byte by byte select.
// - High word read returns program bits 23..16 with upper data byte zero.
// - High byte read returns bits 23..16, or zero for the phantom byte.
// - Page bit 7 picks user space or configuration space.
// - Table address is page value above the 16-bit effective address.
// - Addresses step by two per word; low and high spaces share ranges.
// - Page erase clears 1024 words on page-aligned boundaries.
// - Program writes two adjacent words at a pair-aligned address.
// - Processor is stalled while program or erase runs.
// - Start bit launches the self-timed operation; hardware clears it at end.
// - Two key values written back to back unlock one start.
// - Operation address is upper register above lower register.
// - Enable bit allows program and erase; zero inhibits them.
// - Error flag sets on bad start or bad termination.
// - Halt-in-idle stops flash work in idle; otherwise it continues.
// - Operation codes erase 0011, program 0001; others start nothing.
// - Start, enable, error and op fields reset only on power-on.
// - Power-save request is ignored while an operation runs.
// - With halt-in-idle, flash stays unavailable a regulator delay after idle.
// - Software can set the start bit but never clear it.
module fts_sequencer #(
  parameter int ERASE_CYCLES = fts_pkg::FTS_ERASE_CYC
) (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Warm reset from the reset controller, same clock
  input wire logic warm_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // CPU table instructions and power state
  input fts_pkg::fts_tbl_req_t tbl_req,
  output logic tbl_done,
  output logic [15:0] tbl_rdata,
  output logic cpu_stall,
  input wire logic power_save_instruction,
  input wire logic idle_exit,
  output logic idle_granted,
  output logic flash_ready,
  // Flash array
  output logic [23:0] flash_rd_addr,
  input wire logic [23:0] flash_rd_data,
  output fts_pkg::fts_flash_op_t flash_op
);
  import fts_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    fts_state_t st;
    logic start;
    logic enable;
    logic err;
    logic halt;
    logic [3:0] op;
    logic [7:0] page;
    logic [7:0] adr_up;
    logic [15:0] adr_lo;
    logic [1:0] kseq;
    logic ack;
    logic [31:0] dat;
    logic rd_pend;
    logic rd_high;
    logic rd_byte;
    logic rd_bsel;
    logic tbl_done;
    logic [15:0] tbl_rdata;
    logic [23:0] rd_addr;
    logic [47:0] latch;
    fts_flash_op_t fop;
    logic idle;
    logic [FTS_WAKE_W-1:0] wake_cnt;
    logic stall;
    logic ready;
  } fts_seq_s_t;

  fts_seq_s_t s_ff;
  fts_seq_s_t nxt_s;

  localparam logic [FTS_WAKE_W-1:0] WAKE_LAST = FTS_WAKE_W'(FTS_VREG_CYC - 1);

  logic tmr_done;
  logic tmr_start;
  logic tmr_abort;

  // Merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] sel_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic [15:0] ctrl_view(input fts_seq_s_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[FTS_BIT_START] = s.start;
    v[FTS_BIT_ENABLE] = s.enable;
    v[FTS_BIT_ERR] = s.err;
    v[FTS_BIT_HALT] = s.halt;
    v[FTS_OP_MSB:0] = s.op;
    return v;
  endfunction

  logic wb_req;
  logic wb_wr;
  logic [15:0] ctrl_wr;
  logic start_try;
  logic start_ok;
  logic op_valid;
  logic tbl_take;
  logic [23:0] op_target;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_s = s_ff;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    wb_req = wb_cyc_i && wb_stb_i && !s_ff.ack;
    wb_wr = wb_req && wb_we_i;
    ctrl_wr = sel_merge(ctrl_view(s_ff), wb_dat_i, wb_sel_i);
    start_try = wb_wr && (wb_adr_i == FTS_ADR_CTRL) && wb_sel_i[1]
                && ctrl_wr[FTS_BIT_START] && !s_ff.start;
    op_valid = (ctrl_wr[FTS_OP_MSB:0] == FTS_OP_ERASE)
               || (ctrl_wr[FTS_OP_MSB:0] == FTS_OP_PROG);
    start_ok = start_try && (s_ff.kseq == FTS_KSEQ_OPEN) && ctrl_wr[FTS_BIT_ENABLE]
               && op_valid && (s_ff.st == FTS_ST_IDLE);
    op_target = {s_ff.adr_up, s_ff.adr_lo};
    nxt_s.tbl_done = 1'b0;

    // Wishbone: one wait state, ack drops the cycle after it is given
    nxt_s.ack = wb_req;
    nxt_s.dat = 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        FTS_ADR_CTRL: nxt_s.dat[15:0] = ctrl_view(s_ff);
        FTS_ADR_TGT_UP: nxt_s.dat[7:0] = s_ff.adr_up;
        FTS_ADR_TGT_LO: nxt_s.dat[15:0] = s_ff.adr_lo;
        FTS_ADR_PAGE: nxt_s.dat[7:0] = s_ff.page;
        default: nxt_s.dat = 32'h0000_0000;
      endcase
    end

    if (wb_wr) begin
      // Any write other than the next key value breaks the unlock
      nxt_s.kseq = FTS_KSEQ_NONE;
      unique case (wb_adr_i)
        FTS_ADR_CTRL: begin
          nxt_s.enable = ctrl_wr[FTS_BIT_ENABLE];
          nxt_s.err = ctrl_wr[FTS_BIT_ERR];
          nxt_s.halt = ctrl_wr[FTS_BIT_HALT];
          nxt_s.op = ctrl_wr[FTS_OP_MSB:0];
        end
        FTS_ADR_KEY: begin
          if (wb_sel_i[0] && wb_dat_i[7:0] == FTS_KEY_FIRST) begin
            nxt_s.kseq = FTS_KSEQ_HALF;
          end else if (wb_sel_i[0] && wb_dat_i[7:0] == FTS_KEY_SECOND
                       && s_ff.kseq == FTS_KSEQ_HALF) begin
            nxt_s.kseq = FTS_KSEQ_OPEN;
          end
        end
        FTS_ADR_TGT_UP: nxt_s.adr_up = 8'(sel_merge({8'h00, s_ff.adr_up}, wb_dat_i, wb_sel_i));
        FTS_ADR_TGT_LO: nxt_s.adr_lo = sel_merge(s_ff.adr_lo, wb_dat_i, wb_sel_i);
        FTS_ADR_PAGE: nxt_s.page = 8'(sel_merge({8'h00, s_ff.page}, wb_dat_i, wb_sel_i));
        default: nxt_s.kseq = FTS_KSEQ_NONE;
      endcase
      // A zero written to start leaves it alone
      if (start_ok) begin
        nxt_s.start = 1'b1;
      end else if (start_try) begin
        nxt_s.err = 1'b1;
      end
    end

    // Launch of the self-timed operation
    if (start_ok) begin
      nxt_s.st = FTS_ST_BUSY;
      tmr_start = 1'b1;
      nxt_s.fop.erase = (ctrl_wr[FTS_OP_MSB:0] == FTS_OP_ERASE);
      nxt_s.fop.prog = (ctrl_wr[FTS_OP_MSB:0] == FTS_OP_PROG);
      nxt_s.fop.data = s_ff.latch;
      if (ctrl_wr[FTS_OP_MSB:0] == FTS_OP_ERASE) begin
        nxt_s.fop.addr = op_target & FTS_PAGE_MASK;
      end else begin
        nxt_s.fop.addr = op_target & FTS_PAIR_MASK;
      end
    end

    // Operation, idle and wake sequencing
    unique case (s_ff.st)
      FTS_ST_IDLE: begin
        if (s_ff.idle && idle_exit) begin
          nxt_s.idle = 1'b0;
          if (s_ff.halt) begin
            nxt_s.st = FTS_ST_WAKE;
            nxt_s.wake_cnt = WAKE_LAST;
          end
        end else if (power_save_instruction && !start_ok) begin
          nxt_s.idle = 1'b1;
        end
      end
      FTS_ST_BUSY: begin
        // Power-save is simply not granted here
        if (s_ff.idle && idle_exit) begin
          nxt_s.idle = 1'b0;
        end
        if (s_ff.idle && s_ff.halt) begin
          tmr_abort = 1'b1;
          nxt_s.start = 1'b0;
          nxt_s.err = 1'b1;
          nxt_s.fop.erase = 1'b0;
          nxt_s.fop.prog = 1'b0;
          nxt_s.st = FTS_ST_IDLE;
        end else if (tmr_done) begin
          nxt_s.start = 1'b0;
          nxt_s.fop.erase = 1'b0;
          nxt_s.fop.prog = 1'b0;
          nxt_s.st = FTS_ST_IDLE;
        end
      end
      FTS_ST_WAKE: begin
        if (s_ff.wake_cnt == '0) begin
          nxt_s.st = FTS_ST_IDLE;
        end else begin
          nxt_s.wake_cnt = s_ff.wake_cnt - 1'b1;
        end
      end
      default: nxt_s.st = FTS_ST_IDLE;
    endcase
    nxt_s.stall = (nxt_s.st == FTS_ST_BUSY);
    // Flash is unusable in idle with halt set, and until the regulator settles
    nxt_s.ready = (nxt_s.st == FTS_ST_IDLE) && !(nxt_s.idle && s_ff.halt);

    // Table accesses, taken only while flash is usable
    tbl_take = tbl_req.valid && s_ff.ready && !s_ff.rd_pend && !s_ff.tbl_done;
    if (tbl_take && !tbl_req.write) begin
      nxt_s.rd_addr = {s_ff.page, tbl_req.ea};
      nxt_s.rd_pend = 1'b1;
      nxt_s.rd_high = tbl_req.high;
      nxt_s.rd_byte = tbl_req.byte_mode;
      nxt_s.rd_bsel = tbl_req.ea[0];
    end else if (tbl_take) begin
      // Word index within the pair comes from address bit 1
      nxt_s.tbl_done = 1'b1;
      if (tbl_req.high) begin
        if (!tbl_req.byte_mode || !tbl_req.ea[0]) begin
          nxt_s.latch[tbl_req.ea[1] * 24 + 16 +: 8] = tbl_req.wdata[7:0];
        end
      end else if (!tbl_req.byte_mode) begin
        nxt_s.latch[tbl_req.ea[1] * 24 +: 16] = tbl_req.wdata;
      end else if (tbl_req.ea[0]) begin
        nxt_s.latch[tbl_req.ea[1] * 24 + 8 +: 8] = tbl_req.wdata[7:0];
      end else begin
        nxt_s.latch[tbl_req.ea[1] * 24 +: 8] = tbl_req.wdata[7:0];
      end
    end
    if (s_ff.rd_pend) begin
      nxt_s.rd_pend = 1'b0;
      nxt_s.tbl_done = 1'b1;
      nxt_s.tbl_rdata = 16'h0000;
      if (!s_ff.rd_high && !s_ff.rd_byte) begin
        nxt_s.tbl_rdata = flash_rd_data[15:0];
      end else if (!s_ff.rd_high) begin
        nxt_s.tbl_rdata[7:0] = s_ff.rd_bsel ? flash_rd_data[15:8] : flash_rd_data[7:0];
      end else if (!s_ff.rd_byte) begin
        nxt_s.tbl_rdata[7:0] = flash_rd_data[23:16];
      end else if (!s_ff.rd_bsel) begin
        nxt_s.tbl_rdata[7:0] = flash_rd_data[23:16];
      end
    end

    // Warm reset spares the power-on-only control fields
    if (warm_rst) begin
      nxt_s.halt = 1'b0;
      nxt_s.page = FTS_PAGE_RST;
      nxt_s.adr_up = FTS_ADR_UP_RST;
      nxt_s.adr_lo = FTS_ADR_LO_RST;
      nxt_s.kseq = FTS_KSEQ_NONE;
      nxt_s.ack = 1'b0;
      nxt_s.rd_pend = 1'b0;
      nxt_s.tbl_done = 1'b0;
      nxt_s.idle = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '0;
      s_ff.st <= FTS_ST_IDLE;
      s_ff.op <= FTS_OP_RST;
      s_ff.ready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // Operation timer
  // ****************************************************************
  fts_op_timer #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(FTS_PROG_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(tmr_start),
    .is_erase(nxt_s.fop.erase),
    .abort(tmr_abort),
    .done(tmr_done)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.dat;
  assign tbl_done = s_ff.tbl_done;
  assign tbl_rdata = s_ff.tbl_rdata;
  assign cpu_stall = s_ff.stall;
  assign idle_granted = s_ff.idle;
  assign flash_ready = s_ff.ready;
  assign flash_rd_addr = s_ff.rd_addr;
  assign flash_op = s_ff.fop;
endmodule

//--- fts_pkg.sv
package fts_pkg;

  // ****************************************************************
  // Register map (byte addresses on the 32-bit bus)
  // ****************************************************************
  localparam logic [7:0] FTS_ADR_CTRL = 8'h00;
  localparam logic [7:0] FTS_ADR_KEY = 8'h04;
  localparam logic [7:0] FTS_ADR_TGT_UP = 8'h08;
  localparam logic [7:0] FTS_ADR_TGT_LO = 8'h0c;
  localparam logic [7:0] FTS_ADR_PAGE = 8'h10;

  // ****************************************************************
  // Control register fields and reset values
  // ****************************************************************
  localparam int FTS_BIT_START = 15;
  localparam int FTS_BIT_ENABLE = 14;
  localparam int FTS_BIT_ERR = 13;
  localparam int FTS_BIT_HALT = 12;
  localparam int FTS_OP_MSB = 3;
  localparam logic [3:0] FTS_OP_ERASE = 4'h3;
  localparam logic [3:0] FTS_OP_PROG = 4'h1;
  localparam logic [3:0] FTS_OP_RST = 4'h0;
  localparam logic [7:0] FTS_PAGE_RST = 8'h00;
  localparam logic [7:0] FTS_ADR_UP_RST = 8'h00;
  localparam logic [15:0] FTS_ADR_LO_RST = 16'h0000;
  localparam int FTS_PAGE_SPACE_BIT = 7;

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************
  localparam logic [7:0] FTS_KEY_FIRST = 8'h55;
  localparam logic [7:0] FTS_KEY_SECOND = 8'haa;
  localparam logic [1:0] FTS_KSEQ_NONE = 2'h0;
  localparam logic [1:0] FTS_KSEQ_HALF = 2'h1;
  localparam logic [1:0] FTS_KSEQ_OPEN = 2'h2;

  // ****************************************************************
  // Alignment masks on the 24-bit program address
  // ****************************************************************
  // One erase page is 1024 words, two address units each
  localparam logic [23:0] FTS_PAGE_MASK = 24'hfff800;
  // A double-word pair spans four address units
  localparam logic [23:0] FTS_PAIR_MASK = 24'hfffffc;

  // ****************************************************************
  // Timing at 20 MHz
  // ****************************************************************
  localparam int FTS_CLK_HZ = 20_000_000;
  localparam int FTS_CLK_PERIOD_NS = 50;
  localparam int FTS_T_ERASE_NS = 2_000_000;
  localparam int FTS_T_PROG_NS = 50_000;
  localparam int FTS_T_VREG_NS = 10_000;
  localparam int FTS_ERASE_CYC = (FTS_T_ERASE_NS + FTS_CLK_PERIOD_NS - 1) / FTS_CLK_PERIOD_NS;
  localparam int FTS_PROG_CYC = (FTS_T_PROG_NS + FTS_CLK_PERIOD_NS - 1) / FTS_CLK_PERIOD_NS;
  localparam int FTS_VREG_CYC = (FTS_T_VREG_NS + FTS_CLK_PERIOD_NS - 1) / FTS_CLK_PERIOD_NS;
  localparam int FTS_TMR_W = 20;
  localparam int FTS_WAKE_W = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    FTS_ST_IDLE = 3'b001,
    FTS_ST_BUSY = 3'b010,
    FTS_ST_WAKE = 3'b100
  } fts_state_t;

  typedef struct packed {
    logic valid;
    logic high;
    logic byte_mode;
    logic write;
    logic [15:0] ea;
    logic [15:0] wdata;
  } fts_tbl_req_t;

  typedef struct packed {
    logic erase;
    logic prog;
    logic [23:0] addr;
    logic [47:0] data;
  } fts_flash_op_t;

endpackage

//--- fts_op_timer.sv
`timescale 1ns/1ps
module fts_op_timer #(
  parameter int ERASE_CYCLES = fts_pkg::FTS_ERASE_CYC,
  parameter int PROG_CYCLES = fts_pkg::FTS_PROG_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic is_erase,
  input wire logic abort,
  // Status
  output logic done
);
  import fts_pkg::*;

  typedef struct packed {
    logic run;
    logic done;
    logic [FTS_TMR_W-1:0] cnt;
  } fts_tmr_s_t;

  fts_tmr_s_t tmr_ff;
  fts_tmr_s_t nxt_tmr;

  localparam logic [FTS_TMR_W-1:0] ERASE_LAST = FTS_TMR_W'(ERASE_CYCLES - 1);
  localparam logic [FTS_TMR_W-1:0] PROG_LAST = FTS_TMR_W'(PROG_CYCLES - 1);

  always_comb begin
    nxt_tmr = tmr_ff;
    nxt_tmr.done = 1'b0;
    if (abort) begin
      nxt_tmr.run = 1'b0;
    end else if (start) begin
      nxt_tmr.run = 1'b1;
      nxt_tmr.cnt = is_erase ? ERASE_LAST : PROG_LAST;
    end else if (tmr_ff.run) begin
      if (tmr_ff.cnt == '0) begin
        nxt_tmr.run = 1'b0;
        nxt_tmr.done = 1'b1;
      end else begin
        nxt_tmr.cnt = tmr_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign done = tmr_ff.done;
endmodule

//--- fts_seq_props.sv
`timescale 1ns/1ps
module fts_seq_props #(
  parameter int ERASE_CYCLES = fts_pkg::FTS_ERASE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Table port and power
  input fts_pkg::fts_tbl_req_t tbl_req,
  input wire logic tbl_done,
  input wire logic [15:0] tbl_rdata,
  input wire logic cpu_stall,
  input wire logic power_save_instruction,
  input wire logic idle_granted,
  input wire logic flash_ready,
  // Array side
  input wire logic [23:0] flash_rd_addr,
  input wire logic [23:0] flash_rd_data,
  input fts_pkg::fts_flash_op_t flash_op
);
  import fts_pkg::*;
  logic [23:0] rd_ff;
  logic [15:0] ea_ff;
  int cnt_ff;
  logic er_ff;
  logic ctrl_go;
  assign ctrl_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == FTS_ADR_CTRL
    && wb_dat_i[15] && wb_dat_i[14]
    && (wb_dat_i[3:0] == FTS_OP_ERASE || wb_dat_i[3:0] == FTS_OP_PROG);
  // Array word as seen one cycle late, matching the registered read result
  always_ff @(posedge clk_sys) begin
    rd_ff <= flash_rd_data;
    ea_ff <= tbl_req.ea;
    cnt_ff <= cpu_stall ? cnt_ff + 1 : 0;
    er_ff <= cpu_stall && (er_ff || flash_op.erase);
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_issue;
    $rose(tbl_req.valid) && !tbl_req.write && flash_ready;
  endsequence
  sequence s_rd_done;
    tbl_done && tbl_req.valid && !tbl_req.write;
  endsequence
  a_ack_answer:
  assert property (s_bus_req |=> wb_ack_o) else $error("bus request not answered");
  a_ack_single:
  assert property (wb_ack_o |=> !wb_ack_o) else $error("acknowledge too long");
  a_rd_address:
  assert property (s_rd_issue |=> flash_rd_addr[15:0] == ea_ff ##1 tbl_done)
    else $error("table read address or completion wrong");
  a_rd_low:
  assert property ((s_rd_done and !tbl_req.high) |-> (tbl_req.byte_mode ?
    tbl_rdata[7:0] == (tbl_req.ea[0] ? rd_ff[15:8] : rd_ff[7:0]) : tbl_rdata == rd_ff[15:0]))
    else $error("low table read data wrong");
  a_rd_high:
  assert property ((s_rd_done and tbl_req.high) |-> (tbl_req.byte_mode ?
    tbl_rdata[7:0] == (tbl_req.ea[0] ? 8'h00 : rd_ff[23:16])
    : tbl_rdata == {8'h00, rd_ff[23:16]})) else $error("high table read data wrong");
  a_stall_op:
  assert property (flash_op.erase || flash_op.prog |-> cpu_stall) else $error("no stall");
  a_erase_align:
  assert property (flash_op.erase |-> (flash_op.addr & ~FTS_PAGE_MASK) == 24'h000000
    && !flash_op.prog) else $error("erase target not page aligned");
  a_prog_align:
  assert property (flash_op.prog |-> flash_op.addr[1:0] == 2'h0)
    else $error("program target not pair aligned");
  a_start_cause:
  assert property ($rose(cpu_stall) |-> wb_ack_o && $past(ctrl_go))
    else $error("operation began without an enabled start write");
  a_op_length:
  assert property ($fell(cpu_stall) |-> (er_ff ?
    cnt_ff >= ERASE_CYCLES && cnt_ff <= ERASE_CYCLES + 2
    : cnt_ff >= FTS_PROG_CYC && cnt_ff <= FTS_PROG_CYC + 2))
    else $error("operation length wrong");
  a_psave_busy:
  assert property (power_save_instruction && cpu_stall && !idle_granted |=> !idle_granted)
    else $error("idle granted during an operation");
endmodule

bind fts_sequencer fts_seq_props #(.ERASE_CYCLES(ERASE_CYCLES)) fts_seq_props_inst (
  .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .tbl_req(tbl_req), .tbl_done(tbl_done), .tbl_rdata(tbl_rdata), .cpu_stall(cpu_stall),
  .power_save_instruction(power_save_instruction), .idle_granted(idle_granted),
  .flash_ready(flash_ready), .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
  .flash_op(flash_op)
);

//--- fts_array_model.sv
`timescale 1ns/1ps
module fts_array_model (
  // Read port
  input wire logic [23:0] flash_rd_addr,
  output logic [23:0] flash_rd_data
);
  // Contents follow the word address so neighbouring words differ; bit 0 is ignored
  // because program words sit on even addresses
  assign flash_rd_data = {flash_rd_addr[8:1] ^ flash_rd_addr[23:16], ~flash_rd_addr[16:1]};
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import fts_pkg::*;
  localparam int ERASE_N = 20;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic warm_rst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  fts_tbl_req_t tbl_req = '0;
  logic tbl_done;
  logic [15:0] tbl_rdata;
  logic cpu_stall;
  logic power_save_instruction = 1'b0;
  logic idle_exit = 1'b0;
  logic idle_granted;
  logic flash_ready;
  logic [23:0] flash_rd_addr;
  logic [23:0] flash_rd_data;
  fts_flash_op_t flash_op;
  int n_errors = 0;
  int n_compared = 0;
  fts_sequencer #(.ERASE_CYCLES(ERASE_N)) fts_sequencer_inst (
    .clk_sys(clk_sys), .resetn(resetn), .warm_rst(warm_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .tbl_req(tbl_req),
    .tbl_done(tbl_done), .tbl_rdata(tbl_rdata), .cpu_stall(cpu_stall),
    .power_save_instruction(power_save_instruction), .idle_exit(idle_exit),
    .idle_granted(idle_granted), .flash_ready(flash_ready), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data), .flash_op(flash_op)
  );
  fts_array_model fts_array_model_inst (
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data)
  );
  always #25 clk_sys = ~clk_sys;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are read just after an edge, so they show the value sampled at it
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) tmo();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(q, {16'h0000, e});
  endtask
  task automatic unlock();
    wr(FTS_ADR_KEY, 16'h0055);
    wr(FTS_ADR_KEY, 16'h00aa);
  endtask
  task automatic pulse(input int w);
    @(posedge clk_sys);
    if (w == 0) power_save_instruction <= 1'b1;
    else if (w == 1) idle_exit <= 1'b1;
    else warm_rst <= 1'b1;
    @(posedge clk_sys);
    power_save_instruction <= 1'b0;
    idle_exit <= 1'b0;
    warm_rst <= 1'b0;
  endtask
  task automatic wait_val(input int w, input logic v, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      s = (w == 0) ? cpu_stall : (w == 1) ? flash_ready : idle_granted;
    end while (s !== v && n < 3000);
    if (s !== v) tmo();
  endtask
  // Mode bits of i: 0 high space, 1 byte mode, 2 byte select, 3 next word
  task automatic tbl(input logic [7:0] pg, input int i);
    int k;
    logic [15:0] ea;
    logic [15:0] e;
    logic [23:0] p;
    ea = {14'h048d, i[3], i[2]};
    p = {ea[8:1] ^ pg, ~{pg[0], ea[15:1]}};
    if (!i[0]) e = i[1] ? {8'h00, i[2] ? p[15:8] : p[7:0]} : p[15:0];
    else e = (i[1] && i[2]) ? 16'h0000 : {8'h00, p[23:16]};
    @(posedge clk_sys);
    tbl_req <= '{1'b1, i[0], i[1], 1'b0, ea, 16'h0000};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (tbl_done !== 1'b1 && k < 20);
    if (tbl_done !== 1'b1) tmo();
    tbl_req.valid <= 1'b0;
    chk(tbl_rdata & (i[1] ? 16'h00ff : 16'hffff), e);
    chk(flash_rd_addr, {pg, ea});
  endtask
  task automatic twr(input logic [15:0] ea, input logic hi, input logic [15:0] d);
    int k;
    @(posedge clk_sys);
    tbl_req <= '{1'b1, hi, 1'b0, 1'b1, ea, d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (tbl_done !== 1'b1 && k < 20);
    if (tbl_done !== 1'b1) tmo();
    tbl_req.valid <= 1'b0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] adrs [6] = '{FTS_ADR_CTRL, FTS_ADR_KEY, FTS_ADR_TGT_UP, FTS_ADR_TGT_LO,
                             FTS_ADR_PAGE, 8'h20};
    foreach (adrs[j]) rd(adrs[j], 16'h0000);
    chk({idle_granted, flash_ready}, 32'h1);
  endtask
  task automatic t_table();
    for (int j = 0; j < 2; j++) begin
      wr(FTS_ADR_PAGE, j ? 16'h0081 : 16'h0001);
      for (int i = 0; i < 16; i++) begin
        tbl(j ? 8'h81 : 8'h01, i);
      end
    end
  endtask
  task automatic t_ops();
    int n;
    logic go;
    wr(FTS_ADR_TGT_UP, 16'h0012);
    wr(FTS_ADR_TGT_LO, 16'h3457);
    twr(16'h0000, 1'b0, 16'h1234);
    twr(16'h0002, 1'b0, 16'h5678);
    twr(16'h0002, 1'b1, 16'h00bc);
    for (int op = 0; op < 16; op++) begin
      go = (op == 1) || (op == 3);
      unlock();
      wr(FTS_ADR_CTRL, 16'hc000 | 16'(op));
      chk(cpu_stall, go);
      if (go) begin
        chk(flash_op.addr, op == 3 ? 24'h123000 : 24'h123454);
        chk({flash_op.erase, flash_op.prog}, op == 3 ? 2'b10 : 2'b01);
        chk(flash_op.data[47:24], 24'hbc5678);
        chk(flash_op.data[23:0], 24'h001234);
        wr(FTS_ADR_CTRL, 16'h4000 | 16'(op));
        rd(FTS_ADR_CTRL, 16'hc000 | 16'(op));
        pulse(0);
        @(posedge clk_sys);
        chk(idle_granted, 32'h0);
        wait_val(0, 1'b0, n);
        rd(FTS_ADR_CTRL, 16'h4000 | 16'(op));
      end else begin
        rd(FTS_ADR_CTRL, 16'h6000 | 16'(op));
        wr(FTS_ADR_CTRL, 16'h4000);
      end
    end
  endtask
  // Missing unlock, enable low, and an unlock broken by another write
  task automatic t_bad();
    for (int c = 0; c < 3; c++) begin
      if (c > 0) wr(FTS_ADR_KEY, 16'h0055);
      if (c == 2) wr(FTS_ADR_PAGE, 16'h0000);
      if (c > 0) wr(FTS_ADR_KEY, 16'h00aa);
      wr(FTS_ADR_CTRL, c == 1 ? 16'h8001 : 16'hc001);
      chk(cpu_stall, 32'h0);
      rd(FTS_ADR_CTRL, c == 1 ? 16'h2001 : 16'h6001);
      wr(FTS_ADR_CTRL, 16'h4000);
    end
  endtask
  task automatic t_warm();
    wr(FTS_ADR_CTRL, 16'h5003);
    wr(FTS_ADR_CTRL, 16'hd003);
    wr(FTS_ADR_PAGE, 16'h0081);
    pulse(2);
    rd(FTS_ADR_CTRL, 16'h6003);
    rd(FTS_ADR_PAGE, 16'h0000);
  endtask
  task automatic t_idle(input logic h);
    int n;
    wr(FTS_ADR_CTRL, h ? 16'h5000 : 16'h4000);
    pulse(0);
    wait_val(2, 1'b1, n);
    @(posedge clk_sys);
    chk(flash_ready, {31'h0, !h});
    pulse(1);
    wait_val(1, 1'b1, n);
    chk(h ? (n >= FTS_VREG_CYC && n <= FTS_VREG_CYC + 3) : n == 1, 32'h1);
    chk(idle_granted, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_table();
    t_ops();
    t_bad();
    t_warm();
    t_idle(1'b0);
    t_idle(1'b1);
    tally_and_finish();
  end
endmodule
